/* File: modem_sig_cfg.svh */
// Constants for the four-channel modem signal logic: bit positions, reset values, counts.
`ifndef MODEM_SIG_CFG_SVH
`define MODEM_SIG_CFG_SVH

`define CHANNEL_COUNT      4
`define TX_DEPTH_DEFAULT   64
`define CTRL_TERM_READY_BIT    0
`define CTRL_REQ_SEND_BIT      1
`define STAT_CTS_BIT           4
`define STAT_DSR_BIT           5
`define STAT_RING_BIT          6
`define STAT_CARRIER_BIT       7
`define STAT_DELTA_CTS_BIT     0
`define STAT_DELTA_DSR_BIT     1
`define STAT_RING_TRAIL_BIT    2
`define STAT_DELTA_CARRIER_BIT 3
`define FEAT_AUTO_RTS_BIT      6
`define FEAT_AUTO_CTS_BIT      7
`define CTRL_RESET             8'h00
`define FEAT_RESET             8'h00
`define INPUT_IDLE         1'b1

`endif

/* File: modem_sig_pkg.sv */
// Types shared by the modem signal logic.
package modem_sig_pkg;

  typedef struct packed {
    logic carrier_seen_n;
    logic clear_to_send_n;
    logic data_set_ready_n;
    logic ring_indicate_n;
  } modem_in_type;

  typedef struct packed {
    logic terminal_ready_n;
    logic request_to_send_n;
  } modem_out_type;

  typedef enum logic [1:0] {
    FLOW_OFF,
    FLOW_RUN,
    FLOW_HOLD
  } flow_state_type;

endpackage

/* File: modem_chan.sv */
// One channel of modem signal logic: outputs, status, ring event and flow control.
`timescale 1ns/1ps
`include "modem_sig_cfg.svh"
module modem_chan
  import modem_sig_pkg::*;
#(
  parameter int TX_DEPTH = `TX_DEPTH_DEFAULT
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  input  wire logic [7:0]     ctrl_byte,
  input  wire logic [7:0]     feat_byte,
  input  wire modem_in_type   pins_in,
  input  wire logic [$clog2(TX_DEPTH+1)-1:0] tx_level,
  input  wire logic           rx_above_trigger,
  input  wire logic           status_read,
  output logic [7:0]          status_byte,
  output modem_out_type       pins_out,
  output logic                tx_space_n,
  output logic                tx_allowed,
  output logic                ring_irq
);

  modem_in_type   prev_reg;
  logic [3:0]     delta_reg;
  logic [3:0]     delta_next;
  logic           space;
  flow_state_type flow_reg;

  if (TX_DEPTH < 1) begin : g_depth_check
    $error("TX_DEPTH must be at least one");
  end

  // Free space means at least one empty location remains.
  assign space = (32'(tx_level) < TX_DEPTH); // R1 R2

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_space_n <= 1'b1;
    end else begin
      tx_space_n <= ~space; // R1 R2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prev_reg <= '{default: `INPUT_IDLE};
    end else begin
      prev_reg <= pins_in;
    end
  end

  // A new change wins over the clear that a status read performs in the same cycle.
  always_comb begin
    delta_next = status_read ? 4'h0 : delta_reg;
    if (prev_reg.clear_to_send_n != pins_in.clear_to_send_n) begin
      delta_next[`STAT_DELTA_CTS_BIT] = 1'b1;
    end
    if (prev_reg.data_set_ready_n != pins_in.data_set_ready_n) begin
      delta_next[`STAT_DELTA_DSR_BIT] = 1'b1;
    end
    if (!prev_reg.ring_indicate_n && pins_in.ring_indicate_n) begin
      delta_next[`STAT_RING_TRAIL_BIT] = 1'b1; // R12
    end
    if (prev_reg.carrier_seen_n != pins_in.carrier_seen_n) begin
      delta_next[`STAT_DELTA_CARRIER_BIT] = 1'b1;
    end
  end

  // The interrupt stands with the trailing-ring status bit until software reads the status.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      delta_reg   <= 4'h0;
      status_byte <= 8'h00;
      ring_irq    <= 1'b0;
    end else begin
      delta_reg        <= delta_next;
      status_byte[3:0] <= delta_next;
      status_byte[`STAT_CTS_BIT]     <= ~pins_in.clear_to_send_n; // R5 R6
      status_byte[`STAT_DSR_BIT]     <= ~pins_in.data_set_ready_n; // R8
      status_byte[`STAT_RING_BIT]    <= ~pins_in.ring_indicate_n; // R11
      status_byte[`STAT_CARRIER_BIT] <= ~pins_in.carrier_seen_n; // R4
      ring_irq <= delta_next[`STAT_RING_TRAIL_BIT]; // R12
    end
  end

  // Auto request-to-send drops the line while received data sits above trigger.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flow_reg <= FLOW_OFF;
    end else begin
      case (flow_reg)
        FLOW_OFF: begin
          if (feat_byte[`FEAT_AUTO_RTS_BIT]) begin
            flow_reg <= FLOW_RUN;
          end
        end
        FLOW_RUN: begin
          if (!feat_byte[`FEAT_AUTO_RTS_BIT]) begin
            flow_reg <= FLOW_OFF;
          end else if (rx_above_trigger) begin
            flow_reg <= FLOW_HOLD;
          end
        end
        FLOW_HOLD: begin
          if (!feat_byte[`FEAT_AUTO_RTS_BIT]) begin
            flow_reg <= FLOW_OFF;
          end else if (!rx_above_trigger) begin
            flow_reg <= FLOW_RUN;
          end
        end
        default: flow_reg <= FLOW_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pins_out.terminal_ready_n  <= 1'b1; // R10
      pins_out.request_to_send_n <= 1'b1; // R14
    end else begin
      pins_out.terminal_ready_n  <= ~ctrl_byte[`CTRL_TERM_READY_BIT]; // R9 R10
      // Gating on the enable bit too hands control back on the very edge auto mode is dropped.
      pins_out.request_to_send_n <= ~(ctrl_byte[`CTRL_REQ_SEND_BIT] &&
                                      !(feat_byte[`FEAT_AUTO_RTS_BIT] &&
                                        flow_reg == FLOW_HOLD)); // R13 R15
    end
  end

  // Data-set-ready never reaches this term; only clear-to-send does, and only when enabled.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_allowed <= 1'b1;
    end else begin
      tx_allowed <= !feat_byte[`FEAT_AUTO_CTS_BIT] || !pins_in.clear_to_send_n; // R7 R8
    end
  end

endmodule

/* File: uart_modem_signal_logic.sv */
// Top of the four-channel modem signal logic.
// How it works
// R1 - Channel ready output low while its transmit buffer has a free location.
// R2 - Channel ready output high once its transmit buffer is full.
// R3 - Combined ready output low while any channel has free transmit space.
// R4 - Low carrier-detect input means the modem sees a carrier.
// R5 - Low clear-to-send means the modem accepts transmit data.
// R6 - Clear-to-send state readable in status bit 4.
// R7 - Clear-to-send gates transmit only when feature bit 7 enables it.
// R8 - Data-set-ready low means modem ready; never affects transmit or receive.
// R9 - Control bit 0 set drives terminal-ready output low.
// R10 - Terminal-ready high after control bit 0 cleared and after reset.
// R11 - Low ring input means the line is ringing.
// R12 - Ring input rising to high raises that channel's interrupt.
// R13 - Control bit 1 set drives request-to-send output low.
// R14 - Request-to-send is high after reset.
// R15 - Request-to-send joins flow control only when feature bit 6 enables it.
// R16 - Hosts lacking ready pins read each channel's status registers instead.
// R17 - Four independent channels, each with its own control and status bits.
`timescale 1ns/1ps
`include "modem_sig_cfg.svh"
module uart_modem_signal_logic
  import modem_sig_pkg::*;
#(
  parameter int CHANNELS = `CHANNEL_COUNT,
  parameter int TX_DEPTH = `TX_DEPTH_DEFAULT
) (
  input  wire logic                                  SYS_CLK,
  input  wire logic                                  RST_B,
  input  wire logic [CHANNELS-1:0][7:0]              MODEM_CONTROL_REG,
  input  wire logic [CHANNELS-1:0][7:0]              ENHANCED_FEATURE_REG,
  input  wire logic [CHANNELS-1:0]                   STATUS_READ,
  input  wire modem_in_type [CHANNELS-1:0]           MODEM_IN,
  input  wire logic [CHANNELS-1:0][$clog2(TX_DEPTH+1)-1:0] TX_LEVEL,
  input  wire logic [CHANNELS-1:0]                   RX_ABOVE_TRIGGER,
  output logic [CHANNELS-1:0][7:0]                   MODEM_STATUS_REG,
  output modem_out_type [CHANNELS-1:0]               MODEM_OUT,
  output logic [CHANNELS-1:0]                        CHAN_TX_SPACE_N,
  output logic                                       ANY_TX_SPACE_N,
  output logic [CHANNELS-1:0]                        TX_ALLOWED,
  output logic [CHANNELS-1:0]                        RING_IRQ
);

  logic [CHANNELS-1:0] space_n;

  if (CHANNELS < 1) begin : g_chan_check
    $error("CHANNELS must be at least one");
  end

  // Each channel keeps wholly separate state.
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan // R17
    modem_chan #(
      .TX_DEPTH (TX_DEPTH)
    ) u_chan (
      .sys_clk          (SYS_CLK),
      .rst_b            (RST_B),
      .ctrl_byte        (MODEM_CONTROL_REG[c]),
      .feat_byte        (ENHANCED_FEATURE_REG[c]),
      .pins_in          (MODEM_IN[c]),
      .tx_level         (TX_LEVEL[c]),
      .rx_above_trigger (RX_ABOVE_TRIGGER[c]),
      .status_read      (STATUS_READ[c]),
      .status_byte      (MODEM_STATUS_REG[c]),
      .pins_out         (MODEM_OUT[c]),
      .tx_space_n       (space_n[c]),
      .tx_allowed       (TX_ALLOWED[c]),
      .ring_irq         (RING_IRQ[c])
    );
  end

  assign CHAN_TX_SPACE_N = space_n;

  // Combined output built from the level inputs, so it lines up with the per-channel pins.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ANY_TX_SPACE_N <= 1'b1;
    end else begin
      ANY_TX_SPACE_N <= 1'b1;
      for (int c = 0; c < CHANNELS; c++) begin
        if (32'(TX_LEVEL[c]) < TX_DEPTH) begin
          ANY_TX_SPACE_N <= 1'b0; // R3
        end
      end
    end
  end

endmodule

/* File: uart_modem_signal_logic_assertions.sv */
// Checker for the modem signal logic top, watching channel 0 and the shared ready line.
`timescale 1ns/1ps
module modem_sig_checker
  import modem_sig_pkg::*;
#(parameter int CHANNELS = 4, parameter int TX_DEPTH = 64) (
  input wire logic                                    SYS_CLK,
  input wire logic                                    RST_B,
  input wire logic [CHANNELS-1:0][7:0]                MODEM_CONTROL_REG,
  input wire logic [CHANNELS-1:0][7:0]                ENHANCED_FEATURE_REG,
  input wire modem_in_type [CHANNELS-1:0]             MODEM_IN,
  input wire logic [CHANNELS-1:0][$clog2(TX_DEPTH+1)-1:0] TX_LEVEL,
  input wire logic [CHANNELS-1:0][7:0]                MODEM_STATUS_REG,
  input wire modem_out_type [CHANNELS-1:0]            MODEM_OUT,
  input wire logic [CHANNELS-1:0]                     CHAN_TX_SPACE_N,
  input wire logic                                    ANY_TX_SPACE_N,
  input wire logic [CHANNELS-1:0]                     TX_ALLOWED,
  input wire logic [CHANNELS-1:0]                     RING_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire modem_in_type p = MODEM_IN[0];
  // Outputs after the first edge out of reset still carry reset values, hence the guards.
  a_space_chan: assert property ($past(RST_B) |->
    CHAN_TX_SPACE_N[0] == ($past(TX_LEVEL[0]) >= TX_DEPTH)) else $error("channel ready wrong");
  a_space_any: assert property (ANY_TX_SPACE_N == &CHAN_TX_SPACE_N)
    else $error("combined ready wrong");
  a_status_pins: assert property ($past(RST_B) |->
    MODEM_STATUS_REG[0][4] == !$past(p.clear_to_send_n) &&
    MODEM_STATUS_REG[0][7] == !$past(p.carrier_seen_n)) else $error("status pins wrong");
  a_cts_gate: assert property ($past(RST_B) |-> TX_ALLOWED[0] ==
    !($past(ENHANCED_FEATURE_REG[0][7]) && $past(p.clear_to_send_n))) else $error("cts gate");
  a_dtr_follow: assert property ($past(RST_B) |->
    MODEM_OUT[0].terminal_ready_n == !$past(MODEM_CONTROL_REG[0][0])) else $error("dtr wrong");
  a_rts_manual: assert property ($past(RST_B) && !$past(ENHANCED_FEATURE_REG[0][6]) |->
    MODEM_OUT[0].request_to_send_n == !$past(MODEM_CONTROL_REG[0][1])) else $error("rts wrong");
  a_ring_irq: assert property ($past(RST_B) && $rose(p.ring_indicate_n) |=>
    RING_IRQ[0] && MODEM_STATUS_REG[0][2]) else $error("ring irq missing");
  a_ring_only: assert property ($rose(RING_IRQ[0]) |->
    $past(p.ring_indicate_n) && !$past(p.ring_indicate_n, 2)) else $error("stray ring irq");
  a_reset_idle: assert property (disable iff (1'b0) !RST_B |=>
    MODEM_OUT[0] == 2'b11 && !RING_IRQ[0] && TX_ALLOWED[0]) else $error("reset outputs");
  cover property (RING_IRQ[0]);
  cover property (!TX_ALLOWED[0]);
  cover property (CHAN_TX_SPACE_N[0]);
endmodule
bind uart_modem_signal_logic modem_sig_checker #(.CHANNELS(CHANNELS), .TX_DEPTH(TX_DEPTH))
  chk_i (.*);

/* File: modem_far_end.sv */
// Behavioural modem on the far side of every channel, driving the active-low status pins.
`timescale 1ns/1ps
module modem_far_end
  import modem_sig_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               slow,
  input  wire modem_in_type [3:0] want,
  output modem_in_type [3:0]      pins
);
  modem_in_type [3:0] stage_reg;
  // A slow modem lags one more clock, so the bench cannot lean on a fixed pin latency.
  always_ff @(posedge sys_clk) begin
    stage_reg <= want;
    pins      <= slow ? stage_reg : want;
  end
endmodule

/* File: tb_uart_modem_signal_logic.sv */
// Self-checking bench for the four-channel modem signal logic.
`timescale 1ns/1ps
module tb_uart_modem_signal_logic import modem_sig_pkg::*; ;
  localparam int DEPTH = 64;
  logic                             clk = 1'b0, rst_b = 1'b0, slow = 1'b0, any_n;
  logic [3:0][7:0]                  ctrl = '0, feat = '0, stat;
  logic [3:0]                       st_rd = '0, rxa = '0, space_n, allow, irq;
  logic [3:0][$clog2(DEPTH+1)-1:0]  lvl = '0;
  modem_in_type [3:0]               want = '1, pins;
  modem_out_type [3:0]              mout;
  int                               num_errors = 0, checks_done = 0, cyc = 0;
  always #2.5 clk = ~clk;
  modem_far_end far (.sys_clk(clk), .slow(slow), .want(want), .pins(pins));
  uart_modem_signal_logic #(.TX_DEPTH(DEPTH)) dut (.SYS_CLK(clk), .RST_B(rst_b),
    .MODEM_CONTROL_REG(ctrl), .ENHANCED_FEATURE_REG(feat), .STATUS_READ(st_rd), .MODEM_IN(pins),
    .TX_LEVEL(lvl), .RX_ABOVE_TRIGGER(rxa), .MODEM_STATUS_REG(stat), .MODEM_OUT(mout),
    .CHAN_TX_SPACE_N(space_n), .ANY_TX_SPACE_N(any_n), .TX_ALLOWED(allow), .RING_IRQ(irq));
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_space();
    @(posedge clk) lvl <= {4{7'(DEPTH)}};
    tick(1);
    chk(space_n === 4'hf && any_n === 1'b1, "all full");
    @(posedge clk) lvl[2] <= 7'(DEPTH - 1);
    tick(1);
    chk(space_n === 4'hb && any_n === 1'b0, "one free");
    @(posedge clk) lvl <= '0;
  endtask
  task automatic t_ctrl();
    @(posedge clk) ctrl[1] <= 8'h03;
    tick(1);
    chk(mout[1] === 2'b00 && mout[0] === 2'b11, "outputs on");
    @(posedge clk) ctrl[1] <= 8'h01;
    tick(1);
    chk(mout[1] === 2'b01, "rts off");
    @(posedge clk) ctrl[1] <= 8'h00;
    tick(1);
    chk(mout[1] === 2'b11, "dtr off");
  endtask
  task automatic t_cts();
    slow = 1'b1;
    @(posedge clk) begin
      want[0].clear_to_send_n <= 1'b0;
      want[0].data_set_ready_n <= 1'b0;
      feat[0] <= 8'h80;
    end
    tick(3);
    chk(stat[0][4] === 1'b1 && stat[0][5] === 1'b1 && allow[0] === 1'b1, "cts low");
    @(posedge clk) want[0].clear_to_send_n <= 1'b1;
    tick(3);
    chk(allow[0] === 1'b0 && stat[0][4] === 1'b0, "cts gates");
    @(posedge clk) feat[0] <= 8'h00;
    tick(1);
    chk(allow[0] === 1'b1, "cts status only");
    @(posedge clk) want[0] <= '1;
    tick(3);
    slow = 1'b0;
  endtask
  // Channel 0 carries the ring scenario so the checker's ring assertions see it.
  task automatic t_ring();
    @(posedge clk) begin
      want[0].ring_indicate_n <= 1'b0;
      want[0].carrier_seen_n <= 1'b0;
    end
    tick(2);
    chk(stat[0][6] === 1'b1 && stat[0][7] === 1'b1 && irq === 4'h0, "ring low");
    @(posedge clk) want[0].ring_indicate_n <= 1'b1;
    tick(2);
    chk(irq === 4'h1 && stat[0][2] === 1'b1, "ring end irq");
    @(posedge clk) st_rd[0] <= 1'b1;
    tick(1);
    chk(irq === 4'h0, "irq cleared by read");
    @(posedge clk) st_rd[0] <= 1'b0;
    tick(1);
    chk(stat[0][2] === 1'b0, "read clears");
  endtask
  task automatic t_auto_rts();
    @(posedge clk) begin
      feat[2] <= 8'h40;
      ctrl[2] <= 8'h02;
      rxa[2] <= 1'b1;
    end
    tick(4);
    chk(mout[2].request_to_send_n === 1'b1, "auto rts holds");
    @(posedge clk) feat[2] <= 8'h00;
    tick(1);
    chk(mout[2].request_to_send_n === 1'b0, "manual rts");
  endtask
  // A reset in mid-run must pull driven outputs back to idle, not only the power-up state.
  task automatic t_reset();
    @(posedge clk) ctrl[1] <= 8'h03;
    tick(1);
    @(posedge clk) rst_b <= 1'b0;
    tick(1);
    chk(mout[1] === 2'b11 && space_n === 4'hf && any_n === 1'b1, "mid-run reset");
    @(posedge clk) begin
      rst_b <= 1'b1;
      ctrl[1] <= 8'h00;
    end
    tick(1);
    chk(mout[1] === 2'b11 && space_n === 4'h0, "after release");
  endtask
  // The run needs well under a hundred cycles, so this ceiling only catches a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    tick(2);
    chk(mout === '1 && irq === '0 && stat === '0 && allow === '1, "reset values");
    @(posedge clk) rst_b <= 1'b1;
    t_space();
    t_ctrl();
    t_cts();
    t_ring();
    t_auto_rts();
    t_reset();
    print_verdict();
  end
endmodule
